// file: hdl/acd_top.sv
// Purpose: calibration control, busy status and DMA result streaming to external SRAM
// Assumes: single clock, synchronous inputs, sample_i valid at end of conversion
// Notes:   sample FIFO decouples the converter from the external bus sequencer
`timescale 1ns/1ps

module acd_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // filling side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // draining side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("fifo depth must be a power of two of at least 2");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             push;
    logic             pop;

    // full when pointers differ only in the wrap bit
    assign in_ready_o  = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
    assign out_valid_o = wr_ptr != rd_ptr;
    assign out_data_o  = mem[rd_ptr[AW-1:0]];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // storage has no reset, only pointers do
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data_i;
        end
    end

    // pointer update
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule

module acd_top
    import acd_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // special-function register port
    input  wire logic [7:0]  sfr_addr_i,
    input  wire logic        sfr_wr_i,
    input  wire logic [7:0]  sfr_wdata_i,
    output logic [7:0]       sfr_rdata_o,
    // converter core
    input  wire logic        start_conv_i,
    input  wire logic [11:0] sample_i,
    output logic             busy_o,
    output logic [3:0]       chan_sel_o,
    output logic [11:0]      result_o,
    output logic             result_valid_o,
    output logic [17:0]      cal_sum_o,
    output logic             cal_sum_valid_o,
    output logic             cal_gain_o,
    // external data memory pins
    output logic [7:0]       p0_o,
    output logic             p0_oe_o,
    output logic [7:0]       p2_o,
    output logic             ale_o,
    output logic             wr_n_o
);
    if (FIFO_DEPTH < 2) begin : g_chk
        $error("fifo depth too small");
    end

    // readings per calibration from the averaging code
    function automatic logic [5:0] avg_count(input logic [1:0] code);
        case (code)
            2'b00:   avg_count = 6'h0F;
            2'b01:   avg_count = 6'h01;
            2'b10:   avg_count = 6'h1F;
            default: avg_count = 6'h3F;
        endcase
    endfunction

    logic [7:0]  cal_reg;
    logic [7:0]  ctl2;
    logic [23:0] dma_ptr;
    acd_eng_t    eng;
    logic        cal_active;
    logic [5:0]  cyc;
    logic [5:0]  reads_left;
    logic [17:0] sum;
    logic        cal_done;
    logic        push;
    acd_sample_t push_word;
    logic        f_in_ready;
    logic        f_out_valid;
    logic        f_out_ready;
    acd_sample_t f_out;
    acd_xbus_t   xb;
    acd_sample_t xword;
    logic        xbyte;
    logic        wr_cal;
    logic        dma_en;

    assign wr_cal = sfr_wr_i && (sfr_addr_i == CAL_ADDR);
    assign dma_en = ctl2[DMA_BIT];

    // calibration register; a software write beats the hardware clear
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cal_reg <= CAL_RESET;
        end else if (wr_cal) begin
            cal_reg <= sfr_wdata_i;
            cal_reg[BUSY_BIT] <= 1'b0;
            cal_reg[RSV_HI] <= 1'b0;
            cal_reg[RSV_LO] <= 1'b0;
        end else if (cal_done) begin
            cal_reg[START_BIT] <= 1'b0;
        end
    end

    // second control register, channel select and dma enable
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctl2       <= CTL2_RESET;
            chan_sel_o <= 4'h0;
        end else begin
            if (sfr_wr_i && sfr_addr_i == CTL2_ADDR) begin
                ctl2 <= sfr_wdata_i;
            end
            chan_sel_o <= ctl2[CS_MSB:CS_LSB];
        end
    end

    // read data registered, one cycle after the address
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sfr_rdata_o <= 8'h00;
        end else if (sfr_addr_i == CAL_ADDR) begin
            sfr_rdata_o <= {busy_o, cal_reg[6:0]};
        end else if (sfr_addr_i == CTL2_ADDR) begin
            sfr_rdata_o <= ctl2;
        end else if (sfr_addr_i == PTRL_ADDR) begin
            sfr_rdata_o <= dma_ptr[7:0];
        end else if (sfr_addr_i == PTRM_ADDR) begin
            sfr_rdata_o <= dma_ptr[15:8];
        end else if (sfr_addr_i == PTRP_ADDR) begin
            sfr_rdata_o <= dma_ptr[23:16];
        end else begin
            sfr_rdata_o <= 8'h00;
        end
    end

    assign cal_done = (eng == EN_CONV) && cal_active && cyc == 6'h00 && reads_left == 6'h01;

    // conversion engine; a start while dma is full waits so no sample is lost
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            eng             <= EN_IDLE;
            busy_o          <= 1'b0;
            cal_active      <= 1'b0;
            cyc             <= 6'h00;
            reads_left      <= 6'h00;
            sum             <= 18'h00000;
            result_o        <= 12'h000;
            result_valid_o  <= 1'b0;
            cal_sum_o       <= 18'h00000;
            cal_sum_valid_o <= 1'b0;
            cal_gain_o      <= 1'b0;
        end else begin
            result_valid_o  <= 1'b0;
            cal_sum_valid_o <= 1'b0;
            case (eng)
                EN_IDLE: begin
                    if (cal_reg[START_BIT] && !wr_cal) begin
                        eng        <= EN_CONV;
                        busy_o     <= 1'b1;
                        cal_active <= 1'b1;
                        cyc        <= CONV_LAST;
                        reads_left <= avg_count(cal_reg[AVG_HI:AVG_LO]);
                        sum        <= 18'h00000;
                    end else if (start_conv_i && (!dma_en || f_in_ready)) begin
                        eng        <= EN_CONV;
                        busy_o     <= 1'b1;
                        cal_active <= 1'b0;
                        cyc        <= CONV_LAST;
                    end
                end
                default: begin
                    if (cyc != 6'h00) begin
                        cyc <= cyc - 6'h01;
                    end else if (!cal_active) begin
                        eng            <= EN_IDLE;
                        busy_o         <= 1'b0;
                        result_o       <= sample_i;
                        result_valid_o <= 1'b1;
                    end else if (reads_left == 6'h01) begin
                        eng             <= EN_IDLE;
                        busy_o          <= 1'b0;
                        cal_active      <= 1'b0;
                        cal_sum_o       <= sum + 18'(sample_i);
                        cal_sum_valid_o <= 1'b1;
                        cal_gain_o      <= cal_reg[TYPE_BIT];
                    end else begin
                        sum        <= sum + 18'(sample_i);
                        reads_left <= reads_left - 6'h01;
                        cyc        <= CONV_LAST;
                    end
                end
            endcase
        end
    end

    // every plain conversion goes to the fifo when dma is on
    assign push = (eng == EN_CONV) && !cal_active && cyc == 6'h00 && dma_en;
    assign push_word = '{chan: ctl2[CS_MSB:CS_LSB], data: sample_i};
    assign f_out_ready = (xb == XB_IDLE);

    acd_fifo #(
        .WIDTH ($bits(acd_sample_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (push),
        .in_ready_o  (f_in_ready),
        .in_data_i   (push_word),
        .out_valid_o (f_out_valid),
        .out_ready_i (f_out_ready),
        .out_data_o  (f_out)
    );

    // dma pointer: software loads bytes, the sequencer steps it per byte
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dma_ptr <= PTR_RESET;
        end else if (xb == XB_RECV) begin
            dma_ptr <= dma_ptr + 24'h000001;
        end else if (sfr_wr_i && sfr_addr_i == PTRL_ADDR) begin
            dma_ptr[7:0] <= sfr_wdata_i;
        end else if (sfr_wr_i && sfr_addr_i == PTRM_ADDR) begin
            dma_ptr[15:8] <= sfr_wdata_i;
        end else if (sfr_wr_i && sfr_addr_i == PTRP_ADDR) begin
            dma_ptr[23:16] <= sfr_wdata_i;
        end
    end

    // byte sequencer: channel and high nibble first, then the low byte
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            xb      <= XB_IDLE;
            xword   <= '0;
            xbyte   <= 1'b0;
            p0_o    <= 8'h00;
            p0_oe_o <= 1'b0;
            p2_o    <= 8'h00;
            ale_o   <= 1'b0;
            wr_n_o  <= 1'b1;
        end else begin
            case (xb)
                XB_IDLE: begin
                    p0_oe_o <= 1'b0;
                    if (f_out_valid) begin
                        xword   <= f_out;
                        xbyte   <= 1'b0;
                        xb      <= XB_ADDR;
                        p0_o    <= dma_ptr[7:0];
                        p2_o    <= dma_ptr[23:16];
                        p0_oe_o <= 1'b1;
                        ale_o   <= 1'b1;
                    end
                end
                XB_ADDR: begin
                    xb     <= XB_STRB;
                    ale_o  <= 1'b0;
                    p2_o   <= dma_ptr[15:8];
                    p0_o   <= xbyte ? xword.data[7:0] : {xword.chan, xword.data[11:8]};
                    wr_n_o <= 1'b0;
                end
                XB_STRB: begin
                    xb     <= XB_RECV;
                    wr_n_o <= 1'b1;
                end
                default: begin
                    if (!xbyte) begin
                        xbyte <= 1'b1;
                        xb    <= XB_ADDR;
                        p0_o  <= dma_ptr[7:0] + 8'h01;
                        p2_o  <= 8'((dma_ptr + 24'h000001) >> 16);
                        ale_o <= 1'b1;
                    end else begin
                        xb      <= XB_IDLE;
                        p0_oe_o <= 1'b0;
                    end
                end
            endcase
        end
    end

    // helper: readings taken in the current calibration
    logic [5:0] reads_taken;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reads_taken <= 6'h00;
        end else if (eng == EN_IDLE) begin
            reads_taken <= 6'h00;
        end else if (cal_active && cyc == 6'h00) begin
            reads_taken <= reads_taken + 6'h01;
        end
    end

    a_busy_tracks: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        sfr_addr_i == CAL_ADDR |=> sfr_rdata_o[BUSY_BIT] == $past(busy_o))
        else $error("busy does not show in status read");
    a_busy_drop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (result_valid_o || cal_sum_valid_o) |-> !busy_o && $past(busy_o))
        else $error("busy not cleared at end");
    a_conv_length: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        result_valid_o |-> $past(busy_o, CONV_CYCLES) && !$past(busy_o, CONV_CYCLES + 1))
        else $error("conversion length wrong");
    a_avg_reads: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        cal_done |-> reads_taken + 6'h01 == avg_count(cal_reg[AVG_HI:AVG_LO]))
        else $error("wrong number of readings");
    a_start_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        cal_done && !wr_cal |=> !cal_reg[START_BIT]) else $error("start bit not cleared");
    a_cal_type: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        cal_done |=> cal_gain_o == $past(cal_reg[TYPE_BIT])) else $error("type mismatch");
    a_dma_push: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        push |=> f_out_valid || xb == XB_ADDR) else $error("dma sample lost");
    a_ale_page: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ale_o |-> p0_oe_o && p0_o == dma_ptr[7:0] && p2_o == dma_ptr[23:16])
        else $error("latch strobe without address");
    a_mid_byte: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !wr_n_o |-> p2_o == dma_ptr[15:8] && p0_oe_o ##1 wr_n_o)
        else $error("middle address byte missing");
endmodule

// file: hdl/acd_pkg.sv
// Purpose: shared constants and types for the converter calibration and DMA block
// Assumes: core clock of 20 MHz, special-function register port of the core
// Notes:   offsets, field positions, reset values and cycle counts live here
package acd_pkg;
    // special-function register addresses
    localparam logic [7:0] CAL_ADDR   = 8'hF5;
    localparam logic [7:0] CTL2_ADDR  = 8'hD8;
    localparam logic [7:0] PTRL_ADDR  = 8'hD2;
    localparam logic [7:0] PTRM_ADDR  = 8'hD3;
    localparam logic [7:0] PTRP_ADDR  = 8'hD4;
    // values after reset
    localparam logic [7:0]  CAL_RESET  = 8'h00;
    localparam logic [7:0]  CTL2_RESET = 8'h00;
    localparam logic [23:0] PTR_RESET  = 24'h000000;
    // calibration register fields
    localparam int BUSY_BIT  = 7;
    localparam int RSV_HI    = 6;
    localparam int AVG_HI    = 5;
    localparam int AVG_LO    = 4;
    localparam int RSV_LO    = 3;
    localparam int CAL_ONE   = 2;
    localparam int TYPE_BIT  = 1;
    localparam int START_BIT = 0;
    // second control register fields
    localparam int DMA_BIT   = 6;
    localparam int CS_MSB    = 3;
    localparam int CS_LSB    = 0;
    // conversion time: longest time, so rounded down
    localparam int CLK_KHZ      = 20000;
    localparam int CONV_TIME_NS = 2380;
    localparam int CONV_CYCLES  = (CONV_TIME_NS * CLK_KHZ) / 1000000;
    localparam logic [5:0] CONV_LAST = 6'(CONV_CYCLES - 1);
    // one converted sample with its channel
    typedef struct packed {
        logic [3:0]  chan;
        logic [11:0] data;
    } acd_sample_t;
    // external bus sequencer, gray along XB_IDLE, XB_ADDR, XB_STRB, XB_RECV and back; XB_RECV to XB_ADDR flips two bits
    typedef enum logic [1:0] {
        XB_IDLE = 2'b00,
        XB_ADDR = 2'b01,
        XB_STRB = 2'b11,
        XB_RECV = 2'b10
    } acd_xbus_t;
    typedef enum logic {
        EN_IDLE = 1'b0,
        EN_CONV = 1'b1
    } acd_eng_t;
endpackage

// file: tb/acd_sram_model.sv
// Purpose: behavioural external static memory on the multiplexed address/data port
// Assumes: pins sampled on the core clock rising edge, write-only traffic
// Notes:   reports each byte write so the bench can compare it with its model
`timescale 1ns/1ps
module acd_sram_model (
    // clock
    input  wire logic       clk_i,
    // multiplexed bus pins
    input  wire logic       ale_i,
    input  wire logic       wr_n_i,
    input  wire logic [7:0] p0_i,
    input  wire logic       p0_oe_i,
    input  wire logic [7:0] p2_i,
    // write report
    output logic            wr_seen_o,
    output logic [23:0]     wr_addr_o,
    output logic [7:0]      wr_data_o
);
    logic [7:0] lo_q;
    logic [7:0] page_q;
    logic [7:0] last_q;
    logic [7:0] mem [logic [23:0]];
    initial wr_seen_o = 1'b0;
    // external latches catch low byte and page while the strobe is high
    always @(posedge clk_i) begin
        wr_seen_o <= 1'b0;
        if (ale_i === 1'b1) begin
            lo_q   <= p0_i;
            page_q <= p2_i;
        end
        // undriven data never repeats the old byte, so a dropped enable shows up
        if (wr_n_i === 1'b0) begin
            wr_seen_o <= 1'b1;
            wr_addr_o <= {page_q, p2_i, lo_q};
            wr_data_o <= (p0_oe_i === 1'b1) ? p0_i : ~last_q;
            mem[{page_q, p2_i, lo_q}] = p0_i;
            last_q <= p0_i;
        end
    end
endmodule

// file: tb/acd_top_tb.sv
// Purpose: self-checking bench for calibration control and DMA streaming
// Assumes: 20 MHz core clock, memory model watching the external pins
// Notes:   bench keeps its own pointer and queue of expected byte writes
`timescale 1ns/1ps
module acd_top_tb;
    import acd_pkg::*;
    logic        clk_i, rst_n_i, sfr_wr_i, start_conv_i, hold_s;
    logic [7:0]  sfr_addr_i, sfr_wdata_i, sfr_rdata_o, p0_o, p2_o, wr_data, rd;
    logic [11:0] sample_i, result_o, hist1;
    logic [3:0]  chan_sel_o, chan;
    logic [17:0] cal_sum_o, exp_sum;
    logic        busy_o, result_valid_o, cal_sum_valid_o, cal_gain_o;
    logic        p0_oe_o, ale_o, wr_n_o, wr_seen, cal_type, cal_seen, dma_on;
    logic [23:0] wr_addr, ptr;
    logic [31:0] seed = 32'hE8AFD459;
    logic [31:0] exq [$];
    int          error_cnt, total_checks, busy_cnt, exp_busy, n_res;
    int          ntab [4] = '{15, 1, 31, 63};
    logic [7:0]  addrs [6] = '{CAL_ADDR, CTL2_ADDR, PTRL_ADDR, PTRM_ADDR, PTRP_ADDR, 8'hA7};

    acd_top #(.FIFO_DEPTH(8)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i),
        .sfr_rdata_o(sfr_rdata_o), .start_conv_i(start_conv_i), .sample_i(sample_i),
        .busy_o(busy_o), .chan_sel_o(chan_sel_o), .result_o(result_o),
        .result_valid_o(result_valid_o), .cal_sum_o(cal_sum_o),
        .cal_sum_valid_o(cal_sum_valid_o), .cal_gain_o(cal_gain_o), .p0_o(p0_o),
        .p0_oe_o(p0_oe_o), .p2_o(p2_o), .ale_o(ale_o), .wr_n_o(wr_n_o));
    acd_sram_model sram (.clk_i(clk_i), .ale_i(ale_o), .wr_n_i(wr_n_o), .p0_i(p0_o),
        .p0_oe_i(p0_oe_o), .p2_i(p2_o), .wr_seen_o(wr_seen), .wr_addr_o(wr_addr),
        .wr_data_o(wr_data));

    // core clock, 50 ns period
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // converter data changes every cycle unless a calibration needs it steady
    always @(posedge clk_i) begin
        if (!hold_s) begin
            sample_i <= 12'(xs());
        end
    end

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one-cycle strobe, then a free edge so strobes never collide
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        sfr_addr_i  <= a;
        sfr_wdata_i <= d;
        sfr_wr_i    <= 1'b1;
        @(posedge clk_i);
        sfr_wr_i    <= 1'b0;
    endtask

    // address held two edges so the registered read data has settled
    task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        sfr_addr_i <= a;
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        d = sfr_rdata_o;
    endtask

    task automatic final_report;
        if (error_cnt == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // result monitor: busy length, results, sums and memory traffic
    always @(negedge clk_i) begin
        if (rst_n_i === 1'b1) begin
            if (busy_o === 1'b1) begin
                busy_cnt++;
            end else if (busy_cnt != 0) begin
                chk_val(busy_cnt, exp_busy);
                busy_cnt = 0;
            end
            if (result_valid_o === 1'b1) begin
                chk_val(32'(result_o), 32'(hist1));
                n_res++;
                if (dma_on) begin
                    exq.push_back({ptr, chan, hist1[11:8]});
                    exq.push_back({ptr + 24'h000001, hist1[7:0]});
                    ptr = ptr + 24'h000002;
                end
            end
            if (cal_sum_valid_o === 1'b1) begin
                chk_val(32'(cal_sum_o), 32'(exp_sum));
                chk_val(32'(cal_gain_o), 32'(cal_type));
                cal_seen = 1'b1;
            end
            if (wr_seen === 1'b1) begin
                if (exq.size() == 0) begin
                    chk_val(32'h00000001, 32'h00000000);
                end else begin
                    chk_val({wr_addr, wr_data}, exq.pop_front());
                end
            end
        end
        // value standing before the edge at which the converter result is captured
        hist1 = sample_i;
    end

    // watchdog sized well above the longest calibration plus streaming
    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        final_report();
    end

    initial begin
        rst_n_i = 1'b0; sfr_wr_i = 1'b0; sfr_addr_i = 8'h00; sfr_wdata_i = 8'h00;
        start_conv_i = 1'b0; sample_i = 12'h000; hold_s = 1'b0; dma_on = 1'b0;
        hist1 = 12'h000; chan = 4'h0; ptr = 24'h000000;
        cal_type = 1'b0; cal_seen = 1'b0; exp_sum = 18'h00000;
        error_cnt = 0; total_checks = 0; busy_cnt = 0; exp_busy = 0; n_res = 0;
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        foreach (addrs[i]) begin
            sfr_read(addrs[i], rd);
            chk_reg(rd, 8'h00);
        end
        sfr_write(8'hA7, 8'h5A);
        sfr_read(8'hA7, rd);
        chk_reg(rd, 8'h00);
        sfr_write(CAL_ADDR, 8'h7E);
        sfr_read(CAL_ADDR, rd);
        chk_reg(rd, 8'h36);
        // every averaging code, offset and gain, each with its own channel
        for (int i = 0; i < 4; i++) begin
            cal_type = i[0];
            chan = cal_type ? 4'hC : 4'hB;
            sfr_write(CTL2_ADDR, {4'h0, chan});
            hold_s = 1'b1;
            @(negedge clk_i);
            exp_sum = 18'(ntab[i] * int'(sample_i));
            exp_busy = ntab[i] * CONV_CYCLES;
            cal_seen = 1'b0;
            sfr_write(CAL_ADDR, {2'b00, i[1:0], 2'b01, cal_type, 1'b1});
            repeat (20) @(posedge clk_i);
            start_conv_i <= 1'b1;
            @(posedge clk_i);
            start_conv_i <= 1'b0;
            for (int k = 0; k < 3100 && !cal_seen; k++) @(posedge clk_i);
            chk_val(32'(cal_seen), 32'h00000001);
            sfr_read(CAL_ADDR, rd);
            chk_reg(rd, {2'b00, i[1:0], 2'b01, cal_type, 1'b0});
            chk_reg({4'h0, chan_sel_o}, {4'h0, chan});
        end
        chk_val(n_res, 0);
        // temperature channel never chosen, so no slow converter clock setup is due
        // streaming across a page boundary, conversions back to back
        hold_s = 1'b0;
        chan = 4'h5;
        ptr = 24'hABFFFE;
        dma_on = 1'b1;
        exp_busy = CONV_CYCLES;
        sfr_write(PTRL_ADDR, 8'hFE);
        sfr_write(PTRM_ADDR, 8'hFF);
        sfr_write(PTRP_ADDR, 8'hAB);
        sfr_write(CTL2_ADDR, {4'h4, chan});
        start_conv_i <= 1'b1;
        for (int k = 0; k < 800 && n_res < 6; k++) @(posedge clk_i);
        start_conv_i <= 1'b0;
        repeat (120) @(posedge clk_i);
        chk_val(exq.size(), 0);
        foreach (addrs[i]) begin
            if (i >= 2 && i <= 4) begin
                sfr_read(addrs[i], rd);
                chk_reg(rd, ptr[8*(i-2) +: 8]);
            end
        end
        // with streaming off no memory write may appear
        sfr_write(CTL2_ADDR, {4'h0, chan});
        dma_on = 1'b0;
        start_conv_i <= 1'b1;
        for (int k = 0; k < 300 && n_res < 10; k++) @(posedge clk_i);
        start_conv_i <= 1'b0;
        repeat (120) @(posedge clk_i);
        final_report();
    end
endmodule
